// ===== common/cpu_clock_defines.svh
// Purpose: constants for the cpu clock and standby control block
// Assumes: system clock is clk_sys; divide ratios are in system clock cycles
// Notes:   widths are the documented ones
`ifndef CPU_CLOCK_DEFINES_SVH
`define CPU_CLOCK_DEFINES_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define CPU_CLOCK_CTRL_ADDR    12'hFB3
`define CPU_CLOCK_CTRL_RESET   4'h0
`define CLOCK_SELECT_RESET     2'h0
`define OP_MODE_RESET          2'h0
`define CPU_COUNT_RESET        7'h00
`define CLOCK_SELECT_LSB_POS   0
`define CLOCK_SELECT_MSB_POS   1
`define HALT_REQUEST_BIT_POS   2
`define STOP_REQUEST_BIT_POS   3

// ----------------------------------------
// divide ratios
// ----------------------------------------
`define DIV_SEL0               7'h40
`define DIV_SEL1               7'h10
`define DIV_SEL2               7'h08
`define DIV_SEL3               7'h04
`define PERIPH_DIV_WIDTH       12

`endif

// ===== common/cpu_clock_pkg.sv
// Purpose: types for the cpu clock and standby control block
// Assumes: nothing beyond the defines header
// Notes:   mode and select encodings follow the register fields
package cpu_clock_pkg;

    typedef enum logic [1:0]
    {
        MODE_NORMAL = 2'h0,
        MODE_HALT   = 2'h1,
        MODE_STOP   = 2'h2,
        MODE_BAD    = 2'h3
    } op_mode_type;

    typedef enum logic [1:0]
    {
        SEL_DIV64 = 2'h0,
        SEL_DIV16 = 2'h1,
        SEL_DIV8  = 2'h2,
        SEL_DIV4  = 2'h3
    } clk_sel_type;

endpackage

// ===== rtl/cpu_clock_standby_control.sv
// Purpose: cpu clock divider select, standby mode bits and peripheral divider
// Assumes: cpu core drives data writes and halt/stop instruction strobes on clk_sys
// Notes:   cpu clock is a one-cycle enable pulse, not a gated clock;
//          the core must qualify its own state with cpu_clock_en
//          mode 11 stays in standby until a release, as neither halt nor stop
//
// How it works
// - 4-bit control register at data address FB3H; select low, mode high.
// - select 00/01/10/11 divides system clock by 64/16/8/4.
// - mode 00 normal, 01 halt, 10 stop, 11 prohibited.
// - any mode bit set puts the device in standby.
// - standby release clears both mode bits, returning to normal.
// - stop instruction sets bit 3, halt instruction sets bit 2.
// - halt and stop are accepted regardless of memory bank enable flag.
// - reset clears the register: divide by 64, normal mode.
// - one selected cpu clock period is one machine cycle.
// - system clock divided and fed to peripherals whatever cpu clock.
// - old clock runs at most one machine cycle (64/16/8/4 system clocks) after a select write.
`timescale 1ns/1ps
`include "cpu_clock_defines.svh"

module cpu_clock_standby_control
(
    input  wire logic                          clk_sys,
    input  wire logic                          srst,
    input  wire logic                          data_write,
    input  wire logic [11:0]                   data_addr,
    input  wire logic [3:0]                    data_wdata,
    input  wire logic                          data_read,
    output logic      [3:0]                    data_rdata,
    input  wire logic                          halt_instr,
    input  wire logic                          stop_instr,
    input  wire logic                          memory_bank_enable_flag,
    input  wire logic                          standby_release,
    output logic                               cpu_clock_en,
    output logic                               standby_active,
    output logic                               halt_active,
    output logic                               stop_active,
    output logic                               osc_stop,
    output logic      [`PERIPH_DIV_WIDTH-1:0]  periph_clk_en
);

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    function automatic logic [6:0] div_ratio(input logic [1:0] sel);
        case (sel)
            cpu_clock_pkg::SEL_DIV64: div_ratio = `DIV_SEL0;
            cpu_clock_pkg::SEL_DIV16: div_ratio = `DIV_SEL1;
            cpu_clock_pkg::SEL_DIV8:  div_ratio = `DIV_SEL2;
            default:                  div_ratio = `DIV_SEL3;
        endcase
    endfunction

    // one register answers both strobes, so the match is shared
    function automatic logic reg_hit(input logic [11:0] addr);
        reg_hit = (addr == `CPU_CLOCK_CTRL_ADDR);
    endfunction

    function automatic logic mode_is_halt(input logic [1:0] mode);
        mode_is_halt = (mode == cpu_clock_pkg::MODE_HALT);
    endfunction

    function automatic logic mode_is_stop(input logic [1:0] mode);
        mode_is_stop = (mode == cpu_clock_pkg::MODE_STOP);
    endfunction

    // prohibited code 11 is still standby, though neither halt nor stop
    function automatic logic mode_is_standby(input logic [1:0] mode);
        mode_is_standby = (mode != cpu_clock_pkg::MODE_NORMAL);
    endfunction

    // ----------------------------------------
    // register and divider state
    // ----------------------------------------
    logic [1:0]                   sel_active_q;
    logic [1:0]                   sel_active_d;
    logic [1:0]                   sel_pend_q;
    logic [1:0]                   sel_pend_d;
    logic [1:0]                   mode_q;
    logic [1:0]                   mode_d;
    logic [6:0]                   cpu_cnt_q;
    logic [6:0]                   cpu_cnt_d;
    logic                         cpu_en_q;
    logic                         cpu_en_d;
    logic [`PERIPH_DIV_WIDTH-1:0] per_cnt_q;
    logic [`PERIPH_DIV_WIDTH-1:0] per_cnt_d;
    logic [`PERIPH_DIV_WIDTH-1:0] per_en_q;
    logic [`PERIPH_DIV_WIDTH-1:0] per_en_d;
    logic [3:0]                   rdata_q;
    logic [3:0]                   rdata_d;
    logic                         hit_w;
    logic                         hit_r;
    logic                         boundary;
    logic [6:0]                   ratio;
    logic                         per_run;
    logic [`PERIPH_DIV_WIDTH-1:0] per_tick;
    logic                         standby_q;
    logic                         standby_d;
    logic                         halt_q;
    logic                         halt_d;
    logic                         stop_q;
    logic                         stop_d;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    // writes and reads to any other address are ignored
    assign hit_w = data_write && reg_hit(data_addr);
    assign hit_r = data_read && reg_hit(data_addr);
    assign ratio = div_ratio(sel_active_q);

    // end of an old cpu clock period; also pulses cpu_clock_en outside standby
    assign boundary = (cpu_cnt_q == (ratio - 7'h01));

    // ----------------------------------------
    // control register: pending select and mode bits
    // ----------------------------------------
    always_comb
    begin
        sel_pend_d = sel_pend_q;
        mode_d     = mode_q;
        if (hit_w)
        begin
            // mode bits are not taken from the write; software writes them zero
            sel_pend_d = data_wdata[`CLOCK_SELECT_MSB_POS:`CLOCK_SELECT_LSB_POS];
        end
        // release first, so an instruction in the same cycle still wins
        if (standby_release)
        begin
            mode_d = cpu_clock_pkg::MODE_NORMAL;
        end
        // no bank flag check: the instructions act whatever the bank setting
        if (stop_instr)
        begin
            mode_d[`STOP_REQUEST_BIT_POS-2] = 1'b1;
        end
        if (halt_instr)
        begin
            mode_d[`HALT_REQUEST_BIT_POS-2] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            sel_pend_q <= `CLOCK_SELECT_RESET;
            mode_q     <= `OP_MODE_RESET;
        end
        else
        begin
            sel_pend_q <= sel_pend_d;
            mode_q     <= mode_d;
        end
    end

    // ----------------------------------------
    // cpu clock divider
    // ----------------------------------------
    // divider keeps running in standby so the switch delay stays bounded
    always_comb
    begin
        sel_active_d = sel_active_q;
        cpu_cnt_d    = cpu_cnt_q;
        cpu_en_d     = 1'b0;
        if (boundary)
        begin
            // switching only here keeps every period whole; a write in this
            // cycle is taken at once, so the old clock runs one period at most
            cpu_cnt_d    = `CPU_COUNT_RESET;
            cpu_en_d     = !mode_is_standby(mode_q);
            sel_active_d = sel_pend_d;
        end
        else
        begin
            cpu_cnt_d = cpu_cnt_q + 7'h01;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            sel_active_q <= `CLOCK_SELECT_RESET;
            cpu_cnt_q    <= `CPU_COUNT_RESET;
            cpu_en_q     <= 1'b0;
        end
        else
        begin
            sel_active_q <= sel_active_d;
            cpu_cnt_q    <= cpu_cnt_d;
            cpu_en_q     <= cpu_en_d;
        end
    end

    // ----------------------------------------
    // mode status, registered from the next mode value
    // ----------------------------------------
    // same timing as the mode bits themselves, but driven straight from flops
    always_comb
    begin
        standby_d = mode_is_standby(mode_d);
        halt_d    = mode_is_halt(mode_d);
        stop_d    = mode_is_stop(mode_d);
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            standby_q <= 1'b0;
            halt_q    <= 1'b0;
            stop_q    <= 1'b0;
        end
        else
        begin
            standby_q <= standby_d;
            halt_q    <= halt_d;
            stop_q    <= stop_d;
        end
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    // readback shows the pending select, which is what software last wrote
    always_comb
    begin
        rdata_d = rdata_q;
        if (hit_r)
        begin
            rdata_d = {mode_q, sel_pend_q};
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            rdata_q <= `CPU_CLOCK_CTRL_RESET;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    // ----------------------------------------
    // peripheral divider
    // ----------------------------------------
    // bit k pulses once every 2^(k+1) system clocks; stopped only in stop mode
    assign per_run = !mode_is_stop(mode_q);

    genvar k;
    generate
        for (k = 0; k < `PERIPH_DIV_WIDTH; k = k + 1)
        begin : g_per
            // bit k fires when the low k+1 counter bits are all ones
            assign per_tick[k] = &per_cnt_q[k:0];
        end
    endgenerate

    // frozen rather than cleared in stop, so the tick phase survives a stop
    always_comb
    begin
        per_cnt_d = per_cnt_q;
        per_en_d  = '0;
        if (per_run)
        begin
            per_cnt_d = per_cnt_q + `PERIPH_DIV_WIDTH'(1);
            per_en_d  = per_tick;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            per_cnt_q <= '0;
            per_en_q  <= '0;
        end
        else
        begin
            per_cnt_q <= per_cnt_d;
            per_en_q  <= per_en_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign cpu_clock_en   = cpu_en_q;
    assign standby_active = standby_q;
    assign halt_active    = halt_q;
    assign stop_active    = stop_q;
    // the oscillator is cut only in stop; halt keeps it running for the dividers
    assign osc_stop       = stop_q;
    assign data_rdata     = rdata_q;
    assign periph_clk_en  = per_en_q;

endmodule

// ===== dv/cpu_clock_standby_control_assertions.sv
// Purpose: port checks for the cpu clock and standby control
// Assumes: one clock, srst synchronous high
// Notes:   enable gap of 3 covers the fastest divide
`timescale 1ns/1ps
`include "cpu_clock_defines.svh"
module ccsc_chk
(
    input wire logic                         clk_sys,
    input wire logic                         srst,
    input wire logic                         data_read,
    input wire logic [11:0]                  data_addr,
    input wire logic [3:0]                   data_rdata,
    input wire logic                         halt_instr,
    input wire logic                         stop_instr,
    input wire logic                         standby_release,
    input wire logic                         cpu_clock_en,
    input wire logic                         standby_active,
    input wire logic                         halt_active,
    input wire logic                         stop_active,
    input wire logic                         osc_stop,
    input wire logic [`PERIPH_DIV_WIDTH-1:0] periph_clk_en
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    sequence s_gap;
        !cpu_clock_en [*3];
    endsequence
    a_clock_gap: assert property (cpu_clock_en |=> s_gap) else $error("cpu pulses too close");
    a_standby_quiet: assert property (standby_active && $past(standby_active) |-> !cpu_clock_en)
        else $error("cpu pulse in standby");
    a_halt_set: assert property (!standby_active && halt_instr && !stop_instr |=> halt_active)
        else $error("halt not entered");
    a_stop_set: assert property (!standby_active && stop_instr && !halt_instr |=> stop_active && osc_stop)
        else $error("stop not entered");
    a_release_clr: assert property (standby_release && !halt_instr && !stop_instr |=> !standby_active)
        else $error("release left standby");
    a_mode_code: assert property (halt_active && !standby_release && !stop_instr
        |=> halt_active && !stop_active) else $error("halt mode lost");
    a_read_mode: assert property (data_read && data_addr == 12'hFB3 && !standby_active && !halt_instr
        && !stop_instr |=> data_rdata[3:2] == 2'h0) else $error("mode bits read wrong");
    a_read_hold: assert property (!data_read |=> $stable(data_rdata)) else $error("read data moved");
    a_periph_tick: assert property (periph_clk_en[0] && !stop_instr && !osc_stop
        |=> !periph_clk_en[0] ##1 (periph_clk_en[0] || osc_stop)) else $error("periph tick wrong");
endmodule
bind cpu_clock_standby_control ccsc_chk ccsc_chk_i (.clk_sys(clk_sys), .srst(srst), .data_read(data_read),
    .data_addr(data_addr), .data_rdata(data_rdata), .halt_instr(halt_instr), .stop_instr(stop_instr),
    .standby_release(standby_release), .cpu_clock_en(cpu_clock_en), .standby_active(standby_active),
    .halt_active(halt_active), .stop_active(stop_active), .osc_stop(osc_stop), .periph_clk_en(periph_clk_en));

// ===== dv/cpu_core_model.sv
// Purpose: cpu core side, measures each machine cycle
// Assumes: cpu_clock_en is one pulse per machine cycle
// Notes:   period is stale until two pulses have passed
`timescale 1ns/1ps
module cpu_core_model
(
    input  wire logic       clk_sys,
    input  wire logic       cpu_clock_en,
    output logic      [7:0] period
);
    logic [7:0] count_q;
    always_ff @(posedge clk_sys)
    begin
        count_q <= cpu_clock_en ? 8'h01 : count_q + 8'h01;
        if (cpu_clock_en)
            period <= count_q;
    end
endmodule

// ===== dv/cpu_clock_standby_control_tb.sv
// Purpose: register, clock select and standby tests
// Assumes: inputs driven at falling edge
// Notes:   none
`timescale 1ns/1ps
module cpu_clock_standby_control_tb;
    logic clk_sys = 0, srst = 1, data_write = 0, data_read = 0, halt_instr = 0, stop_instr = 0;
    logic memory_bank_enable_flag = 0, standby_release = 0, cpu_clock_en, standby_active;
    logic halt_active, stop_active, osc_stop;
    logic [11:0] data_addr = 12'hFB3, periph_clk_en;
    logic [3:0] data_wdata = 4'h0, data_rdata;
    logic [7:0] period, div [4] = '{8'h40, 8'h10, 8'h08, 8'h04};
    int mismatches = 0, comparisons = 0;
    cpu_clock_standby_control cpu_clock_standby_control_i (.clk_sys(clk_sys), .srst(srst),
        .data_write(data_write), .data_addr(data_addr), .data_wdata(data_wdata), .data_read(data_read),
        .data_rdata(data_rdata), .halt_instr(halt_instr), .stop_instr(stop_instr),
        .memory_bank_enable_flag(memory_bank_enable_flag), .standby_release(standby_release),
        .cpu_clock_en(cpu_clock_en), .standby_active(standby_active), .halt_active(halt_active),
        .stop_active(stop_active), .osc_stop(osc_stop), .periph_clk_en(periph_clk_en));
    cpu_core_model cpu_core_model_i (.clk_sys(clk_sys), .cpu_clock_en(cpu_clock_en), .period(period));
    initial forever #4 clk_sys = ~clk_sys;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [3:0] d);
        @(negedge clk_sys);
        data_addr = a;
        data_wdata = d;
        data_write = 1;
        @(negedge clk_sys);
        data_write = 0;
    endtask
    task automatic rd(input logic [3:0] exp);
        @(negedge clk_sys);
        data_addr = 12'hFB3;
        data_read = 1;
        @(negedge clk_sys);
        data_read = 0;
        chk({4'h0, data_rdata}, {4'h0, exp});
    endtask
    task automatic fire(input logic h, input logic s, input logic r);
        @(negedge clk_sys);
        {halt_instr, stop_instr, standby_release} = {h, s, r};
        @(negedge clk_sys);
        {halt_instr, stop_instr, standby_release} = 3'h0; // next cycle is the no-operation
    endtask
    // bounded wait so a stuck divider cannot hang the run
    task automatic wait_en(input int n);
        int k = 0;
        repeat (n)
        begin
            @(negedge clk_sys);
            while (cpu_clock_en !== 1'b1 && k < 600)
            begin
                @(negedge clk_sys);
                k++;
            end
        end
        if (k >= 600)
            mismatches++;
    endtask
    // pulses of one peripheral tick over a 64-cycle window
    task automatic per_count(input int k, input logic [7:0] exp);
        logic [7:0] n;
        n = 8'h00;
        repeat (64)
        begin
            @(negedge clk_sys);
            n = n + {7'h0, periph_clk_en[k]};
        end
        chk(n, exp);
    endtask
    initial
    begin
        repeat (6) @(negedge clk_sys);
        srst = 0;
        rd(4'h0);
        wait_en(3);
        chk(period, 8'h40);
        per_count(0, 8'h20);
        wr(12'hFB2, 4'h3);
        rd(4'h0);
        for (int s = 0; s < 4; s++)
        begin
            wr(12'hFB3, s[3:0]);
            rd(s[3:0]);
            wait_en(3);
            chk(period, div[s]);
        end
        memory_bank_enable_flag = 1;
        fire(1, 0, 0);
        chk({6'h0, halt_active, standby_active}, 8'h03);
        rd(4'h7);
        per_count(3, 8'h04);
        fire(1, 0, 1);
        rd(4'h7);
        fire(0, 0, 1);
        rd(4'h3);
        memory_bank_enable_flag = 0;
        fire(0, 1, 0);
        chk({5'h0, osc_stop, stop_active, halt_active}, 8'h06);
        rd(4'hB);
        per_count(0, 8'h00);
        fire(0, 0, 1);
        wait_en(3);
        chk(period, 8'h04);
        fire(1, 0, 0);
        srst = 1;
        repeat (2) @(negedge clk_sys);
        srst = 0;
        rd(4'h0);
        stop_test();
    end
    initial
    begin
        #400000;
        mismatches++;
        stop_test();
    end
endmodule
